/* File: pkg/pew_pkg.sv */
package pew_pkg;
  // Clock, timing, sizes and bit positions
  localparam int CLK_MHZ = 25;
  localparam int BLC_MAX_US = 150;
  localparam int BLC_CYC = BLC_MAX_US * CLK_MHZ;
  localparam int ERASE_SETUP_US = 1;
  localparam int ERASE_SETUP_CYC = ERASE_SETUP_US * CLK_MHZ;
  localparam int ERASE_PULSE_MS = 10;
  localparam int ERASE_PULSE_CYC = ERASE_PULSE_MS * 1000 * CLK_MHZ;
  localparam int STROBE_CYC = 4;
  localparam int STROBE_HIGH_CYC = 4;
  localparam int PAGE_BYTES = 64;
  localparam int ADDR_W = 13;
  localparam int DATA_W = 8;
  localparam int PAGE_LSB = 6;
  localparam int TOGGLE_BIT = 6;
  localparam int POLL_BIT = 7;
  localparam int FIFO_DEPTH = 8;
  localparam int PROT_LEN = 3;
  typedef enum logic [1:0] {PEW_CMD_PAGE, PEW_CMD_ERASE} pew_cmd_e;
endpackage

/* File: verification/pew_dev_model.sv */
`timescale 1ns/1ps
// Device model: page latch, load window, write timer, end-of-write status
module pew_dev_model
  import pew_pkg::*;
#(
  parameter int WIN_CYC = 12,
  parameter int WR_CYC = 60,
  parameter int ER_CYC = 100
) (
  input wire logic core_clk,
  input wire logic chipSel_n,
  input wire logic outGate_n,
  input wire logic writeStb_n,
  input wire logic eraseHv,
  input wire logic [ADDR_W-1:0] memAddr,
  input wire logic [DATA_W-1:0] dataOut,
  input wire logic dataOe_n,
  output logic [DATA_W-1:0] dataIn,
  output int faults
);
  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
  logic [ADDR_W-1:0] pa [0:PAGE_BYTES-1];
  logic [DATA_W-1:0] pd [0:PAGE_BYTES-1];
  logic [ADDR_W-1:0] pollA;
  logic [DATA_W-1:0] last = 8'h00;
  logic ldPrev = 1'b0, rdPrev = 1'b0, tog = 1'b0, junk = 1'b0, polled = 1'b0;
  int n = 0, gap = 0, wr = 0, hvCnt = 0, weCnt = 0;
  wire ld = !chipSel_n && !writeStb_n && !eraseHv;
  wire rd = !chipSel_n && !outGate_n && !eraseHv;
  wire ldFall = ld && !ldPrev;
  wire rdFall = rd && !rdPrev;
  // Deselected bus flips every cycle so a stale value never passes
  assign dataIn = !rd ? {DATA_W{junk}} :
                  (wr > 0) ? {~last[7], tog, last[5:0]} : mem[memAddr];
  initial faults = 0;
  initial for (int i = 0; i < (1 << ADDR_W); i++) mem[i] = 8'hFF;
  // Loads, window close, write period, erase; a read also ends the window
  always @(posedge core_clk) begin
    ldPrev <= ld;
    rdPrev <= rd;
    junk <= ~junk;
    hvCnt <= eraseHv ? hvCnt + 1 : 0;
    weCnt <= !eraseHv ? 0 : (!chipSel_n && !writeStb_n) ? weCnt + 1 : weCnt;
    if ((ld && !outGate_n) || (rd && !dataOe_n)) faults <= faults + 1;
    if (!eraseHv && hvCnt > 0) begin
      if (weCnt < ER_CYC || hvCnt < weCnt + 2 * ERASE_SETUP_CYC) faults <= faults + 1;
      else for (int i = 0; i < (1 << ADDR_W); i++) mem[i] <= 8'hFF;
    end
    if (wr > 0) begin
      wr <= wr - 1;
      if (rdFall) begin
        tog <= ~tog;
        pollA <= memAddr;
        polled <= 1'b1;
        if (polled && memAddr !== pollA) faults <= faults + 1;
      end
    end else if (ldFall) begin
      if (n > 0 && memAddr[12:6] !== pa[0][12:6]) faults <= faults + 1;
      if (n >= PAGE_BYTES) faults <= faults + 1;
      else begin
        pa[n] <= memAddr;
        pd[n] <= dataOut;
        n <= n + 1;
      end
      last <= dataOut;
      gap <= 0;
    end else if (n > 0 && (gap == WIN_CYC || rdFall)) begin
      for (int i = 0; i < n; i++) mem[pa[i]] <= pd[i];
      n <= 0;
      wr <= WR_CYC;
      polled <= 1'b0;
    end else gap <= gap + 1;
  end
endmodule

/* File: verification/testbench.sv */
`timescale 1ns/1ps
module testbench;
  import pew_pkg::*;
  localparam int ERASE_SIM = 100;
  logic core_clk = 1'b0, rst = 1'b1, byteValid = 1'b0, byteLast = 1'b0, eraseReq = 1'b0;
  logic [ADDR_W-1:0] byteAddr = 13'h0000;
  logic [DATA_W-1:0] byteData = 8'h00;
  logic byteReady, busy, writeDone, pageError, chipSel_n, outGate_n, writeStb_n, eraseHv, dataOe_n;
  logic [ADDR_W-1:0] memAddr;
  logic [DATA_W-1:0] dataOut, dataIn;
  int faults, num_errors = 0, num_checks = 0, seed = 32'h127b, sawErr = 0;
  logic [DATA_W-1:0] exp [int];
  // Clock and sticky page-error monitor
  always #20 core_clk = ~core_clk;
  always @(posedge core_clk) if (pageError === 1'b1) sawErr <= 1;
  pew_host #(.ERASE_CYC(ERASE_SIM)) i_dut (.core_clk(core_clk), .rst(rst),
    .byteValid(byteValid), .byteReady(byteReady), .byteAddr(byteAddr), .byteData(byteData),
    .byteLast(byteLast), .eraseReq(eraseReq), .busy(busy), .writeDone(writeDone),
    .pageError(pageError), .chipSel_n(chipSel_n), .outGate_n(outGate_n),
    .writeStb_n(writeStb_n), .eraseHv(eraseHv), .memAddr(memAddr), .dataOut(dataOut),
    .dataOe_n(dataOe_n), .dataIn(dataIn));
  pew_dev_model #(.ER_CYC(ERASE_SIM)) i_mem (.core_clk(core_clk), .chipSel_n(chipSel_n),
    .outGate_n(outGate_n), .writeStb_n(writeStb_n), .eraseHv(eraseHv), .memAddr(memAddr),
    .dataOut(dataOut), .dataOe_n(dataOe_n), .dataIn(dataIn), .faults(faults));
  task automatic close_out();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chkMem(input string what, input logic [7:0] e, input logic [7:0] s);
    num_checks++;
    if (s !== e) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, e, s);
    end
  endtask
  task automatic chkVal(input string what, input logic [31:0] e, input logic [31:0] s);
    num_checks++;
    if (s !== e) begin
      num_errors++;
      $display("wrong value %s expected %0d seen %0d", what, e, s);
    end
  endtask
  // One stream byte, held until accepted; FIFO back-pressure is waited out
  task automatic push(input int a, input int d, input logic l);
    int k = 0;
    @(negedge core_clk);
    byteValid = 1'b1;
    byteAddr = a[12:0];
    byteData = d[7:0];
    byteLast = l;
    exp[a[12:0]] = d[7:0];
    while (byteReady !== 1'b1) begin
      @(negedge core_clk);
      if (++k > 5000) begin
        num_errors++;
        close_out();
      end
    end
    @(negedge core_clk);
    byteValid = 1'b0;
  endtask
  task automatic waitDone();
    int k;
    @(negedge core_clk);
    for (k = 0; k < 20000 && writeDone !== 1'b1; k++) @(negedge core_clk);
    if (k == 20000) begin
      num_errors++;
      close_out();
    end
    // Erase lands in the model one edge after done, so let it settle
    repeat (2) @(negedge core_clk);
  endtask
  task automatic chkAll();
    foreach (exp[a]) chkMem("mem byte", exp[a], i_mem.mem[a]);
  endtask
  // Main sequence
  initial begin
    int base;
    repeat (2) @(posedge core_clk);
    @(negedge core_clk) rst = 1'b0;
    chkVal("busy", 0, busy);
    push($random(seed) & 13'h1FFF, $random(seed) & 8'hFF, 1'b1);
    waitDone();
    chkAll();
    // Full page of 64 bytes through the 8-word FIFO
    base = $random(seed) & 13'h1FC0;
    for (int i = 0; i < PAGE_BYTES; i++) push(base + i, $random(seed) & 8'hFF, i == 63);
    waitDone();
    chkAll();
    chkVal("page error", 0, sawErr);
    // Load that strays onto the next page splits into two writes
    base = (base + 64) & 13'h1FC0;
    for (int i = 0; i < 5; i++) push(base + i * 30, $random(seed) & 8'hFF, i == 4);
    waitDone();
    waitDone();
    chkAll();
    chkVal("page error", 1, sawErr);
    // Chip erase wipes every written byte
    @(negedge core_clk) eraseReq = 1'b1;
    repeat (2) @(negedge core_clk);
    eraseReq = 1'b0;
    waitDone();
    foreach (exp[a]) exp[a] = 8'hFF;
    chkAll();
    base = $random(seed) & 13'h1FC0;
    for (int i = 0; i < 3; i++) push(base + i, $random(seed) & 8'hFF, i == 2);
    waitDone();
    chkAll();
    chkVal("device faults", 0, faults);
    chkVal("busy", 0, busy);
    close_out();
  end
endmodule

/* File: verilog/pew_fifo.sv */
`timescale 1ns/1ps
module pew_fifo #(
  parameter int WIDTH = 21,
  parameter int DEPTH = 8
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr_r;
  logic [AW-1:0] rdPtr_r;
  logic [AW:0] count_r;
  wire doPush = inValid && inReady;
  wire doPop = outValid && outReady;

  // Honest full and empty from the occupancy count
  assign inReady = (count_r != (AW+1)'(DEPTH));
  assign outValid = (count_r != '0);
  assign outData = mem[rdPtr_r];

  // Pointers wrap; depth must be a power of two
  always_ff @(posedge core_clk) begin
    if (rst) begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      count_r <= '0;
    end else begin
      if (doPush) begin
        mem[wrPtr_r] <= inData;
        wrPtr_r <= wrPtr_r + AW'(1);
      end
      if (doPop) rdPtr_r <= rdPtr_r + AW'(1);
      count_r <= count_r + (AW+1)'(doPush) - (AW+1)'(doPop);
    end
  end
endmodule

/* File: verilog/pew_host.sv */
`timescale 1ns/1ps
module pew_host
  import pew_pkg::*;
#(
  parameter int ERASE_CYC = pew_pkg::ERASE_PULSE_CYC
) (
  input wire logic core_clk,
  input wire logic rst,
  // Byte stream: page_address_bits from first byte, last marks end of load
  input wire logic byteValid,
  output logic byteReady,
  input wire logic [pew_pkg::ADDR_W-1:0] byteAddr,
  input wire logic [pew_pkg::DATA_W-1:0] byteData,
  input wire logic byteLast,
  input wire logic eraseReq,
  output logic busy,
  output logic writeDone,
  output logic pageError,
  // Device pins
  output logic chipSel_n,
  output logic outGate_n,
  output logic writeStb_n,
  output logic eraseHv,
  output logic [pew_pkg::ADDR_W-1:0] memAddr,
  output logic [pew_pkg::DATA_W-1:0] dataOut,
  output logic dataOe_n,
  input wire logic [pew_pkg::DATA_W-1:0] dataIn
);
  import pew_pkg::*;
  localparam int FW = ADDR_W + DATA_W + 1;

  typedef enum logic [3:0] {
    ST_IDLE, ST_SETUP, ST_STB, ST_GAP, ST_POLL_LO, ST_POLL_HI,
    ST_ER_SETUP, ST_ER_PULSE, ST_ER_HOLD
  } pew_state_e;

  pew_state_e state_r;
  logic [31:0] timer_r;
  logic [6:0] bytes_r;
  logic [ADDR_W-1:PAGE_LSB] page_r;
  logic [ADDR_W-1:0] pollAddr_r;
  logic [DATA_W-1:0] dOut_r;
  logic [ADDR_W-1:0] aOut_r;
  logic lastSeen_r;
  logic havePrev_r;
  logic prevTog_r;
  logic [DATA_W-1:0] sync1_r;
  logic [DATA_W-1:0] sync2_r;
  logic err_r;
  logic done_r;
  logic fOutValid;
  logic fOutReady;
  logic [FW-1:0] fOutData;

  pew_fifo #(.WIDTH(FW), .DEPTH(FIFO_DEPTH)) uFifo (
    .core_clk(core_clk),
    .rst(rst),
    .inValid(byteValid),
    .inReady(byteReady),
    .inData({byteLast, byteAddr, byteData}),
    .outValid(fOutValid),
    .outReady(fOutReady),
    .outData(fOutData)
  );

  // FIFO head fields
  wire hdLast = fOutData[FW-1];
  wire [ADDR_W-1:0] hdAddr = fOutData[FW-2:DATA_W];
  wire [DATA_W-1:0] hdData = fOutData[DATA_W-1:0];
  wire firstByte = (bytes_r == 7'h00);
  wire pageMatch = firstByte || (hdAddr[ADDR_W-1:PAGE_LSB] == page_r);
  wire pageFull = (bytes_r == 7'(PAGE_BYTES));
  wire canLoad = fOutValid && pageMatch && !pageFull && !lastSeen_r;
  // Gap timer starts after the strobe, so strobe and setup cycles come off the limit
  wire gapExpired = (timer_r >= 32'(BLC_CYC - STROBE_CYC - 2));
  wire startPoll = (state_r == ST_GAP) && (gapExpired || lastSeen_r || (fOutValid && !canLoad));
  // Toggle compare on synchronised line 6; equal twice means done
  wire togNow = sync2_r[TOGGLE_BIT];
  wire pollStable = havePrev_r && (togNow == prevTog_r);

  assign fOutReady = (state_r == ST_IDLE || state_r == ST_GAP) && canLoad;
  assign busy = (state_r != ST_IDLE) || fOutValid;
  assign writeDone = done_r;
  assign pageError = err_r;
  assign memAddr = aOut_r;
  assign dataOut = dOut_r;
  // Strobes decoded from state only, so gate and write can never overlap
  // Erase pulse is a long write strobe while the gate sits at high voltage
  assign writeStb_n = !(state_r == ST_STB || state_r == ST_ER_PULSE);
  assign chipSel_n = !(state_r == ST_STB || state_r == ST_POLL_LO || state_r == ST_ER_SETUP
                       || state_r == ST_ER_PULSE || state_r == ST_ER_HOLD);
  assign outGate_n = (state_r != ST_POLL_LO);
  assign dataOe_n = !(state_r == ST_SETUP || state_r == ST_STB || state_r == ST_GAP);
  assign eraseHv = (state_r == ST_ER_SETUP || state_r == ST_ER_PULSE || state_r == ST_ER_HOLD);

  // Pin inputs pass two flops before any compare
  always_ff @(posedge core_clk) begin
    sync1_r <= dataIn;
    sync2_r <= sync1_r;
  end

  // Sequencer
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_r <= ST_IDLE;
      timer_r <= '0;
      bytes_r <= '0;
      page_r <= '0;
      pollAddr_r <= '0;
      aOut_r <= '0;
      dOut_r <= '0;
      lastSeen_r <= 1'b0;
      havePrev_r <= 1'b0;
      prevTog_r <= 1'b0;
      err_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      done_r <= 1'b0;
      unique case (state_r)
        ST_IDLE, ST_GAP: begin
          timer_r <= timer_r + 32'd1;
          if (fOutReady) begin
            if (firstByte) page_r <= hdAddr[ADDR_W-1:PAGE_LSB];
            aOut_r <= {(firstByte ? hdAddr[ADDR_W-1:PAGE_LSB] : page_r),
                       hdAddr[PAGE_LSB-1:0]};
            dOut_r <= hdData;
            pollAddr_r <= hdAddr;
            lastSeen_r <= hdLast;
            bytes_r <= bytes_r + 7'd1;
            timer_r <= '0;
            state_r <= ST_SETUP;
          end else if (startPoll) begin
            // Gap limit, last byte, full page or foreign page closes the load
            err_r <= fOutValid && !pageMatch && !lastSeen_r && !pageFull;
            aOut_r <= pollAddr_r;
            timer_r <= '0;
            havePrev_r <= 1'b0;
            state_r <= ST_POLL_HI;
          end else if (state_r == ST_IDLE && eraseReq) begin
            timer_r <= '0;
            state_r <= ST_ER_SETUP;
          end
        end
        ST_SETUP: state_r <= ST_STB;
        ST_STB: begin
          timer_r <= timer_r + 32'd1;
          if (timer_r == 32'(STROBE_CYC - 1)) begin
            timer_r <= '0;
            state_r <= ST_GAP;
          end
        end
        ST_POLL_HI: begin
          // Device ignores loads until done, so nothing else is issued
          timer_r <= timer_r + 32'd1;
          if (timer_r == 32'(STROBE_HIGH_CYC - 1)) begin
            timer_r <= '0;
            state_r <= ST_POLL_LO;
          end
        end
        ST_POLL_LO: begin
          timer_r <= timer_r + 32'd1;
          if (timer_r == 32'(STROBE_CYC - 1)) begin
            timer_r <= '0;
            prevTog_r <= togNow;
            havePrev_r <= 1'b1;
            if (pollStable) begin
              done_r <= 1'b1;
              bytes_r <= '0;
              lastSeen_r <= 1'b0;
              state_r <= ST_IDLE;
            end else begin
              state_r <= ST_POLL_HI;
            end
          end
        end
        ST_ER_SETUP: begin
          timer_r <= timer_r + 32'd1;
          if (timer_r == 32'(ERASE_SETUP_CYC - 1)) begin
            timer_r <= '0;
            state_r <= ST_ER_PULSE;
          end
        end
        ST_ER_PULSE: begin
          timer_r <= timer_r + 32'd1;
          if (timer_r == 32'(ERASE_CYC - 1)) begin
            timer_r <= '0;
            state_r <= ST_ER_HOLD;
          end
        end
        ST_ER_HOLD: begin
          timer_r <= timer_r + 32'd1;
          if (timer_r == 32'(ERASE_SETUP_CYC - 1)) begin
            timer_r <= '0;
            done_r <= 1'b1;
            state_r <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // Polling compares settle after two sync flops inside the strobe
  chk_gate_never_overlap: assert property (@(posedge core_clk) disable iff (rst)
    !(writeStb_n == 1'b0 && chipSel_n == 1'b0 && outGate_n == 1'b0))
    else $error("gate low during write strobe");
  chk_page_fixed: assert property (@(posedge core_clk) disable iff (rst)
    ($fell(writeStb_n) && bytes_r > 7'd1) |-> memAddr[ADDR_W-1:PAGE_LSB] == page_r)
    else $error("page address moved");
  chk_page_bound: assert property (@(posedge core_clk) disable iff (rst)
    bytes_r <= 7'(PAGE_BYTES))
    else $error("page over 64 bytes");
  chk_poll_addr: assert property (@(posedge core_clk) disable iff (rst)
    (state_r == ST_POLL_LO && $past(state_r) == ST_POLL_LO) |-> $stable(memAddr))
    else $error("poll address moved");
  chk_gap_bound: assert property (@(posedge core_clk) disable iff (rst)
    (state_r == ST_GAP) |-> timer_r <= 32'(BLC_CYC - STROBE_CYC - 2))
    else $error("byte gap too long");
  chk_erase_len: assert property (@(posedge core_clk) disable iff (rst)
    $rose(state_r == ST_ER_HOLD) |-> $past(timer_r) == 32'(ERASE_CYC - 1))
    else $error("erase pulse short");
  chk_done_stable: assert property (@(posedge core_clk) disable iff (rst)
    (writeDone && $past(state_r) == ST_POLL_LO) |-> $past(pollStable))
    else $error("done without stable toggle");
  chk_no_load_poll: assert property (@(posedge core_clk) disable iff (rst)
    (state_r == ST_POLL_HI) |=> writeStb_n)
    else $error("load during write");

  // Erase watch counters, cleared whenever high voltage is off
  logic [31:0] hvRun_r;
  logic [31:0] pulseRun_r;
  always_ff @(posedge core_clk) begin
    if (rst || !eraseHv) begin
      hvRun_r <= '0;
      pulseRun_r <= '0;
    end else begin
      hvRun_r <= hvRun_r + 32'd1;
      if (!writeStb_n) pulseRun_r <= pulseRun_r + 32'd1;
    end
  end
  chk_erase_setup: assert property (@(posedge core_clk) disable iff (rst)
    ($fell(writeStb_n) && eraseHv) |-> hvRun_r >= 32'(ERASE_SETUP_CYC))
    else $error("erase setup short");
  chk_erase_pulse: assert property (@(posedge core_clk) disable iff (rst)
    ($rose(writeStb_n) && eraseHv) |-> pulseRun_r >= 32'(ERASE_CYC))
    else $error("erase strobe short");
endmodule
